// *** mde_pkg.sv ***
// Shared constants and types of the multiply/divide engine.
// Assumes one clock and an issuing integer pipeline that holds a request
// while the engine reports a stall.

package mde_pkg;

  typedef enum logic [2:0] {
    MDE_OP_MUL_PAIR,
    MDE_OP_MUL_ACC,
    MDE_OP_MUL_SUB,
    MDE_OP_MUL_GPR,
    MDE_OP_DIV
  } mde_op_t;

  typedef enum logic [1:0] {
    MDE_DIV_IDLE,
    MDE_DIV_ITER,
    MDE_DIV_PAD,
    MDE_DIV_WB
  } mde_div_state_t;

  localparam int MDE_WORD_W   = 32;
  localparam int MDE_HALF_W   = 16;
  localparam int MDE_MCAND_W  = 33;
  localparam int MDE_MPLIER_W = 17;
  localparam int MDE_CNT_W    = 6;

  // Iterations of a full divide, and those skipped by early-in detection
  localparam logic [5:0] MDE_DIV_STEPS   = 6'h20;
  localparam logic [5:0] MDE_DIV_SKIP_8  = 6'h17;
  localparam logic [5:0] MDE_DIV_SKIP_16 = 6'h0F;
  localparam logic [5:0] MDE_DIV_SKIP_24 = 6'h07;
  localparam logic [5:0] MDE_DIV_SKIP_32 = 6'h00;

  // Repeat interval of a divide per dividend size, in clock cycles
  localparam logic [5:0] MDE_DIV_REP_8  = 6'h0B;
  localparam logic [5:0] MDE_DIV_REP_16 = 6'h12;
  localparam logic [5:0] MDE_DIV_REP_24 = 6'h19;
  localparam logic [5:0] MDE_DIV_REP_32 = 6'h20;

  localparam logic [63:0] MDE_PAIR_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] MDE_WORD_RST = 32'h0000_0000;

endpackage

// *** mde_booth_mult.sv ***
// Radix-4 booth-recoded signed multiplier, purely combinational.
// Assumes the caller extends both operands so that they are signed.
`timescale 1ns/1ps
`default_nettype none

module mde_booth_mult
  import mde_pkg::*;
#(
  parameter int MCAND_W  = MDE_MCAND_W,
  parameter int MPLIER_W = MDE_MPLIER_W
) (
  input  wire logic signed [MCAND_W-1:0]          mcand_i,
  input  wire logic signed [MPLIER_W-1:0]         mplier_i,
  output logic signed      [MCAND_W+MPLIER_W-1:0] prod_o
);

  localparam int GRP = (MPLIER_W + 1) / 2;
  localparam int PW  = MCAND_W + MPLIER_W;

  if (MCAND_W < 2 || MPLIER_W < 2) begin : g_bad_width
    $error("mde_booth_mult: operand widths must be at least 2");
  end

  always_comb begin
    logic signed [2*GRP:0]  ext;
    logic signed [PW-1:0]   m;
    logic signed [PW-1:0]   pp;
    logic signed [PW-1:0]   sum;
    ext = {(2*GRP)'(mplier_i), 1'b0};
    m   = PW'(mcand_i);
    pp  = '0;
    sum = '0;
    // Each group of three bits selects 0, +-1 or +-2 times the multiplicand
    for (int i = 0; i < GRP; i++) begin
      case (ext[2*i +: 3])
        3'b001, 3'b010: pp = m;
        3'b011:         pp = m <<< 1;
        3'b100:         pp = -(m <<< 1);
        3'b101, 3'b110: pp = -m;
        default:        pp = '0;
      endcase
      sum = sum + (pp <<< (2 * i));
    end
    prod_o = sum;
  end

endmodule // mde_booth_mult

`default_nettype wire

// *** mde_mul_div_engine.sv ***
// Multiply/divide engine beside the integer pipeline.
// Assumes the issuer holds issue_valid_i and its operands steady while
// issue_stall_o is high; an operation is taken when valid and not stalled.
`timescale 1ns/1ps
`default_nettype none

module mde_mul_div_engine
  import mde_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        issue_valid_i,
  input  wire mde_op_t     issue_op_i,
  input  wire logic        issue_signed_i,
  input  wire logic [31:0] first_operand_i,
  input  wire logic [31:0] second_operand_i,
  output logic             issue_stall_o,
  output logic             gpr_result_valid_o,
  output logic [31:0]      gpr_result_o,
  output logic [31:0]      result_high_word_o,
  output logic [31:0]      result_low_word_o,
  output logic             div_done_o
);

  // Multiply size detection looks at the second operand only
  function automatic logic second_is_short(input logic [31:0] v,
                                           input logic        sgn);
    second_is_short = sgn ? (v[31:15] == {17{v[15]}})
                          : (v[31:16] == 16'h0000);
  endfunction

  // Early-in test on the dividend sign extension
  function automatic logic [5:0] div_skip(input logic [31:0] v,
                                          input logic        sgn);
    logic [31:0] s;
    s = (sgn && v[31]) ? ~v : v;
    if (sgn ? (s[31:7] == 25'h0) : (s[31:8] == 24'h0))
      div_skip = MDE_DIV_SKIP_8;
    else if (sgn ? (s[31:15] == 17'h0) : (s[31:16] == 16'h0))
      div_skip = MDE_DIV_SKIP_16;
    else if (sgn ? (s[31:23] == 9'h0) : (s[31:24] == 8'h0))
      div_skip = MDE_DIV_SKIP_24;
    else
      div_skip = MDE_DIV_SKIP_32;
  endfunction

  // Idle cycles that stretch a short divide to its documented repeat rate
  function automatic logic [5:0] div_pad(input logic [5:0] skip);
    logic [5:0] rep;
    case (skip)
      MDE_DIV_SKIP_8:  rep = MDE_DIV_REP_8;
      MDE_DIV_SKIP_16: rep = MDE_DIV_REP_16;
      MDE_DIV_SKIP_24: rep = MDE_DIV_REP_24;
      default:         rep = MDE_DIV_REP_32;
    endcase
    div_pad = 6'(rep + skip - MDE_DIV_STEPS);
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v,
                                        input logic        sgn);
    abs32 = (sgn && v[31]) ? (32'h0000_0000 - v) : v;
  endfunction

  // One restoring step: returns {remainder, shifted dividend/quotient}
  function automatic logic [63:0] div_step(input logic [31:0] rem,
                                           input logic [31:0] dvd,
                                           input logic [31:0] dvs);
    logic [32:0] t;
    t = {rem, dvd[31]} - {1'b0, dvs};
    if (!t[32])
      div_step = {t[31:0], dvd[30:0], 1'b1};
    else
      div_step = {rem[30:0], dvd[31], dvd[30:0], 1'b0};
  endfunction

  // Multiply group state
  logic                     mp2_busy;
  mde_op_t                  mp2_op;
  logic signed [32:0]       mp2_mcand;
  logic signed [16:0]       mp2_upper;
  logic signed [49:0]       mp2_plo;
  logic        [63:0]       pair;
  logic                     gpr_stage_v;
  logic        [31:0]       gpr_stage;
  logic                     gpr_out_v;
  logic        [31:0]       gpr_out;
  logic                     next_mp2_busy;
  mde_op_t                  next_mp2_op;
  logic signed [32:0]       next_mp2_mcand;
  logic signed [16:0]       next_mp2_upper;
  logic signed [49:0]       next_mp2_plo;
  logic        [63:0]       next_pair;
  logic                     next_gpr_stage_v;
  logic        [31:0]       next_gpr_stage;
  logic                     next_gpr_out_v;
  logic        [31:0]       next_gpr_out;

  // Divide group state
  mde_div_state_t           div_state;
  logic        [5:0]        div_cnt;
  logic        [5:0]        div_pad_len;
  logic        [31:0]       div_rem;
  logic        [31:0]       div_dvd;
  logic        [31:0]       div_dvs;
  logic                     div_neg_q;
  logic                     div_neg_r;
  logic                     div_done;
  mde_div_state_t           next_div_state;
  logic        [5:0]        next_div_cnt;
  logic        [5:0]        next_div_pad_len;
  logic        [31:0]       next_div_rem;
  logic        [31:0]       next_div_dvd;
  logic        [31:0]       next_div_dvs;
  logic                     next_div_neg_q;
  logic                     next_div_neg_r;
  logic                     next_div_done;

  // Issue control and datapath wires
  logic                     mul_kind;
  logic                     pair_op;
  logic                     short_op2;
  logic                     div_active;
  logic                     div_wb;
  logic                     stall;
  logic                     accept;
  logic                     mul_fire;
  mde_op_t                  done_op;
  logic signed [32:0]       mul_mcand;
  logic signed [16:0]       mul_mplier;
  logic signed [49:0]       mul_prod;
  logic        [63:0]       done_prod;
  logic        [31:0]       step_rem;
  logic        [31:0]       step_dvd;
  logic        [5:0]        skip;

  always_comb begin
    mul_kind   = issue_op_i != MDE_OP_DIV;
    pair_op    = mul_kind && (issue_op_i != MDE_OP_MUL_GPR);
    short_op2  = second_is_short(second_operand_i, issue_signed_i);
    div_active = (div_state == MDE_DIV_ITER) ||
                 (div_state == MDE_DIV_PAD);
    div_wb     = div_state == MDE_DIV_WB;
    // The write-back cycle only blocks the multiplies that write the pair, not a divide
    stall      = issue_valid_i &&
                 (div_active ||
                  (mul_kind && mp2_busy) ||
                  (pair_op && div_wb));
    accept     = issue_valid_i && !stall;
    skip       = div_skip(first_operand_i, issue_signed_i);
  end

  assign issue_stall_o = stall;

  // Second pass reuses the multiplier, so the first pass takes the low half
  always_comb begin
    if (mp2_busy) begin
      mul_mcand  = mp2_mcand;
      mul_mplier = mp2_upper;
    end else begin
      mul_mcand  = {issue_signed_i & first_operand_i[31], first_operand_i};
      mul_mplier = (short_op2 && issue_signed_i) ? second_operand_i[16:0]
                 : {1'b0, second_operand_i[15:0]};
    end
  end

  mde_booth_mult #(
    .MCAND_W  (MDE_MCAND_W),
    .MPLIER_W (MDE_MPLIER_W)
  ) u_booth (
    .mcand_i  (mul_mcand),
    .mplier_i (mul_mplier),
    .prod_o   (mul_prod)
  );

  always_comb begin
    {step_rem, step_dvd} = div_step(div_rem, div_dvd, div_dvs);
    done_prod = mp2_busy ? 64'(mp2_plo) + (64'(mul_prod) <<< MDE_HALF_W)
                         : 64'(mul_prod);
    done_op   = mp2_busy ? mp2_op : issue_op_i;
    mul_fire  = mp2_busy || (accept && mul_kind && short_op2);
    next_mp2_busy  = accept && mul_kind && !short_op2;
    next_mp2_op    = next_mp2_busy ? issue_op_i : mp2_op;
    next_mp2_mcand = mul_mcand;
    next_mp2_upper = {issue_signed_i & second_operand_i[31],
                      second_operand_i[31:16]};
    next_mp2_plo   = mul_prod;
    next_pair      = pair;
    if (mul_fire) begin
      case (done_op)
        MDE_OP_MUL_PAIR: next_pair = done_prod;
        MDE_OP_MUL_ACC:  next_pair = pair + done_prod;
        MDE_OP_MUL_SUB:  next_pair = pair - done_prod;
        default:         next_pair = pair;
      endcase
    end
    if (div_wb) begin
      next_pair = {div_neg_r ? 32'h0000_0000 - step_rem : step_rem,
                   div_neg_q ? 32'h0000_0000 - step_dvd : step_dvd};
    end
    // Register-writing multiplies take one more stage to the result port
    next_gpr_stage_v = mul_fire && (done_op == MDE_OP_MUL_GPR);
    next_gpr_stage   = done_prod[31:0];
    next_gpr_out_v   = gpr_stage_v;
    next_gpr_out     = gpr_stage_v ? gpr_stage : gpr_out;
  end

  always_comb begin
    next_div_state   = div_state;
    next_div_cnt     = div_cnt;
    next_div_pad_len = div_pad_len;
    next_div_rem     = div_rem;
    next_div_dvd     = div_dvd;
    next_div_dvs     = div_dvs;
    next_div_neg_q   = div_neg_q;
    next_div_neg_r   = div_neg_r;
    next_div_done    = div_wb;
    case (div_state)
      MDE_DIV_IDLE: ;
      MDE_DIV_ITER: begin
        next_div_rem = step_rem;
        next_div_dvd = step_dvd;
        if (div_cnt == 6'h01) begin
          next_div_state = (div_pad_len != 6'h00) ? MDE_DIV_PAD
                                                  : MDE_DIV_WB;
          next_div_cnt   = div_pad_len;
        end else begin
          next_div_cnt = div_cnt - 6'h01;
        end
      end
      MDE_DIV_PAD: begin
        if (div_cnt == 6'h01)
          next_div_state = MDE_DIV_WB;
        else
          next_div_cnt = div_cnt - 6'h01;
      end
      MDE_DIV_WB: next_div_state = MDE_DIV_IDLE;
      default:    next_div_state = MDE_DIV_IDLE;
    endcase
    // A new divide may load while the previous one writes back
    if (accept && (issue_op_i == MDE_OP_DIV)) begin
      next_div_state   = MDE_DIV_ITER;
      next_div_cnt     = 6'(MDE_DIV_STEPS - 6'h01 - skip);
      next_div_pad_len = div_pad(skip);
      next_div_rem     = MDE_WORD_RST;
      next_div_dvd     = abs32(first_operand_i, issue_signed_i) << skip;
      next_div_dvs     = abs32(second_operand_i, issue_signed_i);
      next_div_neg_q   = issue_signed_i &&
                         (first_operand_i[31] ^ second_operand_i[31]);
      next_div_neg_r   = issue_signed_i && first_operand_i[31];
    end
  end

  // Runs on every edge: no stall of the integer pipeline reaches it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mp2_busy    <= 1'b0;
      mp2_op      <= MDE_OP_MUL_PAIR;
      mp2_mcand   <= '0;
      mp2_upper   <= '0;
      mp2_plo     <= '0;
      pair        <= MDE_PAIR_RST;
      gpr_stage_v <= 1'b0;
      gpr_stage   <= MDE_WORD_RST;
      gpr_out_v   <= 1'b0;
      gpr_out     <= MDE_WORD_RST;
    end else begin
      mp2_busy    <= next_mp2_busy;
      mp2_op      <= next_mp2_op;
      mp2_mcand   <= next_mp2_mcand;
      mp2_upper   <= next_mp2_upper;
      mp2_plo     <= next_mp2_plo;
      pair        <= next_pair;
      gpr_stage_v <= next_gpr_stage_v;
      gpr_stage   <= next_gpr_stage;
      gpr_out_v   <= next_gpr_out_v;
      gpr_out     <= next_gpr_out;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_state   <= MDE_DIV_IDLE;
      div_cnt     <= 6'h00;
      div_pad_len <= 6'h00;
      div_rem     <= MDE_WORD_RST;
      div_dvd     <= MDE_WORD_RST;
      div_dvs     <= MDE_WORD_RST;
      div_neg_q   <= 1'b0;
      div_neg_r   <= 1'b0;
      div_done    <= 1'b0;
    end else begin
      div_state   <= next_div_state;
      div_cnt     <= next_div_cnt;
      div_pad_len <= next_div_pad_len;
      div_rem     <= next_div_rem;
      div_dvd     <= next_div_dvd;
      div_dvs     <= next_div_dvs;
      div_neg_q   <= next_div_neg_q;
      div_neg_r   <= next_div_neg_r;
      div_done    <= next_div_done;
    end
  end

  assign gpr_result_valid_o = gpr_out_v;
  assign gpr_result_o       = gpr_out;
  assign result_high_word_o = pair[63:32];
  assign result_low_word_o  = pair[31:0];
  assign div_done_o         = div_done;

  // Reference values for the checks below
  logic [63:0] exp_prod;
  logic [31:0] exp_low;
  logic [31:0] h_a;
  logic [31:0] h_b;
  logic        h_sgn;
  logic        acc_div;
  always_comb begin
    exp_prod = 64'({{32{issue_signed_i & first_operand_i[31]}},
                    first_operand_i} *
                   {{32{issue_signed_i & second_operand_i[31]}},
                    second_operand_i});
    exp_low  = exp_prod[31:0];
    acc_div  = accept && (issue_op_i == MDE_OP_DIV);
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h_a   <= MDE_WORD_RST;
      h_b   <= MDE_WORD_RST;
      h_sgn <= 1'b0;
    end else if (acc_div) begin
      h_a   <= first_operand_i;
      h_b   <= second_operand_i;
      h_sgn <= issue_signed_i;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_long_pass;
    mp2_busy ##1 !mp2_busy;
  endsequence
  sequence s_div8_run;
    div_active [*8] ##1 div_active ##1 div_active ##1 div_wb;
  endsequence

  long_mul_pass_a: assert property (
    accept && mul_kind && !short_op2 |=> s_long_pass)
    else $error("long multiply did not take exactly two passes");
  long_mul_stall_a: assert property (
    issue_valid_i && mul_kind && mp2_busy |-> issue_stall_o)
    else $error("multiply issued into a busy multiplier");
  short_mul_rate_a: assert property (
    issue_valid_i && mul_kind && !mp2_busy &&
    div_state == MDE_DIV_IDLE |-> !issue_stall_o)
    else $error("multiply stalled with multiplier free");
  pair_short_lat_a: assert property (
    accept && issue_op_i == MDE_OP_MUL_PAIR && short_op2
    |=> pair == $past(exp_prod))
    else $error("short pair multiply result wrong after one cycle");
  pair_long_lat_a: assert property (
    accept && issue_op_i == MDE_OP_MUL_PAIR && !short_op2
    |=> pair == $past(pair) ##1 pair == $past(exp_prod, 2))
    else $error("long pair multiply result wrong after two cycles");
  acc_short_val_a: assert property (
    accept && issue_op_i == MDE_OP_MUL_ACC && short_op2
    |=> pair == $past(pair) + $past(exp_prod))
    else $error("accumulate did not add product to pair");
  gpr_short_lat_a: assert property (
    accept && issue_op_i == MDE_OP_MUL_GPR && short_op2
    |-> ##2 gpr_result_valid_o && gpr_result_o == $past(exp_low, 2))
    else $error("short register multiply not ready after two cycles");
  // A short register multiply just before may still pulse in cycle 1
  gpr_long_lat_a: assert property (
    accept && issue_op_i == MDE_OP_MUL_GPR && !short_op2
    |-> ##1 mp2_busy ##1 !gpr_result_valid_o
        ##1 gpr_result_valid_o && gpr_result_o == $past(exp_low, 3))
    else $error("long register multiply not ready after three cycles");
  div_stall_a: assert property (
    issue_valid_i && div_active |-> issue_stall_o)
    else $error("operation issued while divide active");
  div_short_time_a: assert property (
    acc_div && skip == MDE_DIV_SKIP_8 |=> s_div8_run ##1 div_done_o)
    else $error("8-bit divide timing wrong");
  div_half_time_a: assert property (
    acc_div && skip == MDE_DIV_SKIP_16 |-> ##18 div_wb ##1 div_done_o)
    else $error("16-bit divide timing wrong");
  div_full_time_a: assert property (
    acc_div && skip == MDE_DIV_SKIP_32 |-> ##32 div_wb ##1 div_done_o)
    else $error("32-bit divide timing wrong");
  div_result_a: assert property (
    div_wb && h_b != MDE_WORD_RST
    |=> $past(h_a) == 32'(result_low_word_o * $past(h_b) +
                          result_high_word_o))
    else $error("quotient and remainder do not rebuild dividend");

endmodule // mde_mul_div_engine

`default_nettype wire

// *** mde_issue_model.sv ***
// Issuing integer pipeline model: offers one engine request at a time.
// Assumes a free-running clock; counts cycles for the bench's timing model.
`timescale 1ns/1ps
`default_nettype none

module mde_issue_model
  import mde_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   stall_i,
  output logic        valid_o,
  output mde_op_t     op_o,
  output logic        sgn_o,
  output logic [31:0] a_o,
  output logic [31:0] b_o
);
  int cyc = 0;

  always @(posedge clk_i) cyc <= cyc + 1;

  initial begin
    valid_o = 1'b0;
    op_o    = MDE_OP_MUL_PAIR;
    sgn_o   = 1'b0;
    a_o     = 32'h0;
    b_o     = 32'h0;
  end

  // Request stays frozen while stalled; the stall settles within the low phase
  task automatic issue(input mde_op_t op, input logic sg,
                       input logic [31:0] a, b, output int ts, tt);
    @(negedge clk_i);
    valid_o = 1'b1;
    op_o    = op;
    sgn_o   = sg;
    a_o     = a;
    b_o     = b;
    ts      = cyc;
    #1;
    while (stall_i) begin
      @(negedge clk_i);
      #1;
    end
    tt = cyc;
    @(posedge clk_i);
  endtask

  // Released operands show garbage, never the last value
  task automatic idle();
    @(negedge clk_i);
    valid_o = 1'b0;
    a_o     = ~a_o;
    b_o     = ~b_o;
  endtask
endmodule // mde_issue_model

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench of the multiply/divide engine against a timing model.
// Assumes mde_issue_model drives the issue port.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import mde_pkg::*;
;
  typedef struct {int c; logic [63:0] v;} mde_ev_t;
  logic        clk, rst_n, stall, valid, sg, gv, dd, s, eg, ed;
  mde_op_t     op, o;
  logic [31:0] a, b, gr, rhw, rlw, x, y;
  logic [63:0] pv = 64'h0;
  int          n_errors = 0;
  int          total_checks = 0;
  int          long_c = -9;
  int          div_c = -99;
  int          div_r = 0;
  mde_ev_t     pq[$];
  mde_ev_t     gq[$];
  int          dq[$];

  mde_issue_model iss_u (.clk_i(clk), .stall_i(stall), .valid_o(valid),
    .op_o(op), .sgn_o(sg), .a_o(a), .b_o(b));
  mde_mul_div_engine dut_u (.clk_sys_i(clk), .rst_n_i(rst_n),
    .issue_valid_i(valid), .issue_op_i(op), .issue_signed_i(sg),
    .first_operand_i(a), .second_operand_i(b), .issue_stall_o(stall),
    .gpr_result_valid_o(gv), .gpr_result_o(gr), .result_high_word_o(rhw),
    .result_low_word_o(rlw), .div_done_o(dd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [63:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic short_b(logic sn, logic [31:0] v);
    return sn ? (v[31:15] == {17{v[15]}}) : (v[31:16] == 16'h0);
  endfunction

  function automatic int div_rep(logic sn, logic [31:0] v);
    if (sn ? v[31:7] == {25{v[7]}} : v[31:8] == 24'h0) return 11;
    if (sn ? v[31:15] == {17{v[15]}} : v[31:16] == 16'h0) return 18;
    if (sn ? v[31:23] == {9{v[23]}} : v[31:24] == 8'h0) return 25;
    return 32;
  endfunction

  function automatic logic blocked(int c, mde_op_t k);
    if (c > div_c && c < div_c + div_r) return 1'b1;
    if (c == div_c + div_r && k <= MDE_OP_MUL_SUB) return 1'b1;
    return c == long_c + 1 && k != MDE_OP_DIV;
  endfunction

  task automatic do_op(mde_op_t k, logic sn, logic [31:0] u, v);
    int ts, tt, c, l;
    logic [63:0] p;
    iss_u.issue(k, sn, u, v, ts, tt);
    c = ts;
    while (blocked(c, k)) c++;
    chk(tt, c);
    p = sn ? $signed({{32{u[31]}}, u}) * $signed({{32{v[31]}}, v})
           : {32'h0, u} * {32'h0, v};
    l = short_b(sn, v) ? 1 : 2;
    if (k != MDE_OP_DIV && l == 2) long_c = tt;
    case (k)
      MDE_OP_MUL_PAIR: pv = p;
      MDE_OP_MUL_ACC:  pv = pv + p;
      MDE_OP_MUL_SUB:  pv = pv - p;
      MDE_OP_MUL_GPR:  gq.push_back('{tt + l + 1, p});
      default: begin
        div_c = tt;
        div_r = div_rep(sn, u);
        l = div_r + 1;
        // Kept apart: a mixed conditional would divide signed operands
        // as unsigned ones
        if (sn) pv = {$signed(u) % $signed(v), $signed(u) / $signed(v)};
        else pv = {u % v, u / v};
        dq.push_back(tt + l);
      end
    endcase
    if (k != MDE_OP_MUL_GPR) pq.push_back('{tt + l, pv});
  endtask

  always @(negedge clk) if (rst_n) begin
    if (pq.size() > 0 && pq[0].c == iss_u.cyc) begin
      chk({rhw, rlw}, pq[0].v);
      void'(pq.pop_front());
    end
    eg = gq.size() > 0 && gq[0].c == iss_u.cyc;
    chk({63'h0, gv}, {63'h0, eg});
    if (eg) begin
      chk({32'h0, gr}, {32'h0, gq[0].v[31:0]});
      void'(gq.pop_front());
    end
    ed = dq.size() > 0 && dq[0] == iss_u.cyc;
    chk({63'h0, dd}, {63'h0, ed});
    if (ed) void'(dq.pop_front());
  end

  task automatic reset_now();
    // Drop the request first, or the held one is taken again after release
    iss_u.idle();
    rst_n = 1'b0;
    pq.delete();
    gq.delete();
    dq.delete();
    pv = 64'h0;
    div_c = -99;
    long_c = -9;
    repeat (6) @(negedge clk);
    chk({rhw, rlw}, 64'h0);
    chk({31'h0, stall, gr}, 64'h0);
    rst_n = 1'b1;
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    void'($urandom(32'h94E16C1A));
    reset_now();
    // Random multiply mix, mostly back to back, short and long multipliers
    for (int i = 0; i < 300; i++) begin
      o = mde_op_t'($urandom_range(0, 3));
      s = $urandom_range(0, 1);
      x = $urandom;
      y = $urandom;
      if ($urandom_range(0, 1)) y = s ? {{16{y[15]}}, y[15:0]} : y & 32'hFFFF;
      else y[31:30] = 2'b10;
      if ($urandom_range(0, 5) == 0) iss_u.idle();
      do_op(o, s, x, y);
    end
    $display("test 1 done");
    // Divides of every dividend size, each chased by another operation
    for (int i = 0; i < 24; i++) begin
      s = i[0];
      x = $urandom;
      // Shift by 24, 16, 8 or 0 so that every dividend size is reached
      if (s) x = $signed(x << (24 - i % 8 / 2 * 8)) >>>
                 (24 - i % 8 / 2 * 8);
      else x = x >> (24 - i % 8 / 2 * 8);
      y = $urandom_range(1, 9999);
      if (s && $urandom_range(0, 1)) y = -y;
      do_op(MDE_OP_DIV, s, x, y);
      do_op(mde_op_t'($urandom_range(0, 4)), s, $urandom, y);
    end
    $display("test 2 done");
    // Reset in the middle of a divide clears every busy state
    do_op(MDE_OP_DIV, 1'b0, 32'hFFFF_FFFF, 32'h3);
    reset_now();
    do_op(MDE_OP_MUL_ACC, 1'b1, 32'hFFFF_FFFE, 32'h7FFF_0003);
    do_op(MDE_OP_MUL_SUB, 1'b0, 32'h8000_0001, 32'h0000_FFFF);
    iss_u.idle();
    repeat (40) @(negedge clk);
    $display("test 3 done");
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
